//--- bench/tb_serdes_transmit_encoder.sv
`timescale 1ns/1ps
module tb_serdes_transmit_encoder;
  import serdes_tx_pkg::*;
  logic                 clk_sys;
  logic                 rstn;
  logic [WORD_BITS-1:0] bus;
  logic                 lk;
  logic                 hk;
  logic                 tpe;
  logic                 word_take;
  logic                 ref_clk;
  logic                 serial_out;
  logic                 rs_q = 1'h0;
  logic                 rd;
  logic                 exp_b[64];
  logic [1:0]           kind[64];
  logic [6:0]           hist;
  logic [19:0]          v;
  int                   error_cnt = 0;
  int                   n_compared = 0;
  int                   cyc = 0;
  int                   sl;
  int                   run;
  int                   j;

  serdes_transmit_encoder dut (
    .clk_sys                 (clk_sys),
    .rstn                    (rstn),
    .parallel_transmit_bus   (bus),
    .low_byte_control_select (lk),
    .high_byte_control_select(hk),
    .test_pattern_enable     (tpe),
    .word_take               (word_take),
    .reference_word_clock    (ref_clk),
    .serial_out              (serial_out)
  );

  word_source src (
    .clk_sys                 (clk_sys),
    .rstn                    (rstn),
    .word_take               (word_take),
    .parallel_transmit_bus   (bus),
    .low_byte_control_select (lk),
    .high_byte_control_select(hk),
    .test_pattern_enable     (tpe)
  );

  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic seen, input logic ev);
    n_compared++;
    if (seen !== ev) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", name, ev, seen);
    end
  endtask

  // symbols of byte 28.5 in send order, first bit in bit 9
  function automatic logic [9:0] sym(input logic k, input logic r);
    return k ? (r ? 10'h305 : 10'h0FA) : 10'h0EA;
  endfunction

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc  <= cyc + 1;
    rs_q <= rstn;
  end

  // scoreboard on the falling edge, where outputs have settled
  always @(negedge clk_sys) begin
    if (!rs_q || !rstn) begin
      sl  = 19;
      rd  = 1'h0;
      run = 0;
      foreach (kind[i]) kind[i] = 2'h0;
    end else begin
      sl = (sl + 1) % 20;
      check("word_take", word_take, sl == 19);
      check("word_clock", ref_clk, sl < 10);
      j = cyc % 64;
      if (kind[j] == 2'h1)
        check("serial_bit", serial_out, exp_b[j]);
      if (kind[j] == 2'h2) begin
        if (run >= 7)
          check("prbs_bit", serial_out, hist[6] ^ hist[5]);
        run++;
        hist = {hist[5:0], serial_out};
      end else begin
        run = 0;
      end
      kind[j] = 2'h0;
    end
    if (rstn && word_take) begin
      v = {sym(lk, rd), sym(hk, rd ^ lk)};
      if (!tpe)
        rd = rd ^ lk ^ hk;
      for (int i = 0; i < 20; i++) begin
        exp_b[(cyc + 37 + i) % 64] = v[19 - i];
        kind[(cyc + 37 + i) % 64]  = tpe ? 2'h2 : 2'h1;
      end
    end
  end

  task automatic drain();
    int i;
    for (i = 0; i < 2000 && src.pending() != 0; i++)
      @(posedge clk_sys);
    if (i == 2000) begin
      error_cnt++;
      end_sim();
    end
    repeat (60) @(posedge clk_sys);
  endtask

  task automatic t_controls();
    for (int c = 0; c < 8; c++)
      src.push(16'hBCBC, c[0], c[1], 1'h0);
    drain();
    $display("test controls done");
  endtask

  task automatic t_prbs();
    for (int c = 0; c < 6; c++)
      src.push(16'h1234, 1'h1, 1'h0, 1'h1);
    src.push(16'hBCBC, 1'h1, 1'h1, 1'h0);
    src.push(16'hBCBC, 1'h1, 1'h0, 1'h0);
    drain();
    $display("test pattern done");
  endtask

  task automatic t_reset_mid();
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("reset_take", word_take, 1'h1);
    check("reset_clock", ref_clk, 1'h0);
    check("reset_serial", serial_out, 1'h0);
    @(posedge clk_sys);
    rstn <= 1'h1;
    for (int c = 0; c < 4; c++)
      src.push(16'hBCBC, 1'h1, c[0], 1'h0);
    drain();
    $display("test mid reset done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("timeout, run cut short");
    end_sim();
  end

  initial begin
    rstn = 1'h0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    t_controls();
    t_prbs();
    t_reset_mid();
    end_sim();
  end
endmodule // tb_serdes_transmit_encoder

//--- bench/word_source.sv
`timescale 1ns/1ps
module word_source (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        word_take,
  output logic      [15:0] parallel_transmit_bus,
  output logic             low_byte_control_select,
  output logic             high_byte_control_select,
  output logic             test_pattern_enable
);
  typedef struct packed {
    logic [15:0] w;
    logic        lk;
    logic        hk;
    logic        tp;
  } src_word_t;

  localparam src_word_t IDLE = '{16'hBCBC, 1'h0, 1'h0, 1'h0};

  src_word_t  q[$];
  src_word_t  cur = IDLE;
  logic [4:0] pc;

  task automatic push(input logic [15:0] w, input logic lk, hk, tp);
    q.push_back('{w, lk, hk, tp});
  endtask

  function automatic int pending();
    return q.size();
  endfunction

  // word shown only in the capture cycle, junk in every other cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc <= 5'h00;
      {parallel_transmit_bus, low_byte_control_select,
       high_byte_control_select, test_pattern_enable} <= cur;
    end else if (word_take) begin
      pc <= 5'h00;
      {parallel_transmit_bus, low_byte_control_select,
       high_byte_control_select, test_pattern_enable} <= ~cur;
    end else begin
      pc <= pc + 5'h01;
      if (pc == 5'h12) begin
        cur = (q.size() != 0) ? q.pop_front() : IDLE;
        {parallel_transmit_bus, low_byte_control_select,
         high_byte_control_select, test_pattern_enable} <= cur;
      end else begin
        {parallel_transmit_bus, low_byte_control_select,
         high_byte_control_select, test_pattern_enable} <= ~cur ^ 19'(pc);
      end
    end
  end
endmodule // word_source

//--- rtl/enc_8b10b.sv
`timescale 1ns/1ps
module enc_8b10b (
  enc_if.enc e
);
  import serdes_tx_pkg::*;

  function automatic int ones6(input logic [5:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 6; i++) begin
      n += int'(v[i]);
    end
    return n;
  endfunction

  // abcdei with a in the top bit, form used at negative disparity
  function automatic logic [5:0] code6(input logic [4:0] x);
    case (x)
      5'h00: code6 = 6'h27;
      5'h01: code6 = 6'h1D;
      5'h02: code6 = 6'h2D;
      5'h03: code6 = 6'h31;
      5'h04: code6 = 6'h35;
      5'h05: code6 = 6'h29;
      5'h06: code6 = 6'h19;
      5'h07: code6 = 6'h38;
      5'h08: code6 = 6'h39;
      5'h09: code6 = 6'h25;
      5'h0A: code6 = 6'h15;
      5'h0B: code6 = 6'h34;
      5'h0C: code6 = 6'h0D;
      5'h0D: code6 = 6'h2C;
      5'h0E: code6 = 6'h1C;
      5'h0F: code6 = 6'h17;
      5'h10: code6 = 6'h1B;
      5'h11: code6 = 6'h23;
      5'h12: code6 = 6'h13;
      5'h13: code6 = 6'h32;
      5'h14: code6 = 6'h0B;
      5'h15: code6 = 6'h2A;
      5'h16: code6 = 6'h1A;
      5'h17: code6 = 6'h3A;
      5'h18: code6 = 6'h33;
      5'h19: code6 = 6'h26;
      5'h1A: code6 = 6'h16;
      5'h1B: code6 = 6'h36;
      5'h1C: code6 = 6'h0E;
      5'h1D: code6 = 6'h2E;
      5'h1E: code6 = 6'h1E;
      default: code6 = 6'h2B;
    endcase
  endfunction

  // fghj with f in the top bit, form used at negative disparity
  function automatic logic [3:0] code4(input logic [2:0] y,
                                       input logic       k,
                                       input logic       alt);
    case (y)
      3'h0: code4 = 4'hB;
      3'h1: code4 = k ? 4'h6 : 4'h9;
      3'h2: code4 = k ? 4'hA : 4'h5;
      3'h3: code4 = 4'hC;
      3'h4: code4 = 4'hD;
      3'h5: code4 = k ? 4'h5 : 4'hA;
      3'h6: code4 = k ? 4'h9 : 4'h6;
      default: code4 = (k || alt) ? 4'h7 : 4'hE;
    endcase
  endfunction

  logic [4:0] x;
  logic [2:0] y;
  logic [5:0] c6;
  logic [5:0] s6;
  logic [3:0] c4;
  logic [3:0] s4;
  logic       flip6;
  logic       flip4;
  logic       rd6;
  logic       alt;
  logic [9:0] v;
  logic [9:0] sym_v;

  always_comb begin
    x     = e.byte_in[4:0];
    y     = e.byte_in[7:5];
    c6    = (e.is_k && x == K28_X) ? K28_CODE6 : code6(x);
    flip6 = ones6(c6) != 3;
    s6    = (e.rd_in && (flip6 || x == 5'h07)) ? ~c6 : c6;
    rd6   = e.rd_in ^ flip6;
    alt   = rd6 ? (x == 5'h0B || x == 5'h0D || x == 5'h0E)
                : (x == 5'h11 || x == 5'h12 || x == 5'h14);
    c4    = code4(y, e.is_k, alt);
    flip4 = ones6({2'h0, c4}) != 2;
    s4    = (rd6 && (flip4 || e.is_k || y == 3'h3)) ? ~c4 : c4;
    v     = {s6, s4};
    for (int i = 0; i < 10; i++) begin
      sym_v[i] = v[9 - i];
    end
    e.sym    = sym_v;
    e.rd_out = rd6 ^ flip4;
  end
endmodule // enc_8b10b

//--- rtl/enc_if.sv
`timescale 1ns/1ps
interface enc_if;
  logic [7:0] byte_in;
  logic       is_k;
  logic       rd_in;
  logic [9:0] sym;
  logic       rd_out;

  modport enc (input byte_in, is_k, rd_in, output sym, rd_out);
  modport user (output byte_in, is_k, rd_in, input sym, rd_out);
endinterface

//--- rtl/prbs7_gen.sv
`timescale 1ns/1ps
module prbs7_gen #(
  parameter int WIDTH = serdes_tx_pkg::SER_BITS
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             step,
  output logic      [WIDTH-1:0] chunk_r
);
  import serdes_tx_pkg::*;

  logic [6:0] state_r;

  // x^7 + x^6 + 1, WIDTH steps per call, first bit in bit 0
  function automatic logic [WIDTH+6:0] run(input logic [6:0] s);
    logic [6:0]       t;
    logic [WIDTH-1:0] b;
    logic             fb;
    t = s;
    b = '0;
    for (int i = 0; i < WIDTH; i++) begin
      fb   = t[6] ^ t[5];
      b[i] = fb;
      t    = {t[5:0], fb};
    end
    return {t, b};
  endfunction

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= PRBS_SEED;
      chunk_r <= '0;
    end else if (step) begin
      {state_r, chunk_r} <= run(state_r);
    end
  end
endmodule // prbs7_gen

//--- rtl/serdes_transmit_encoder.sv
`timescale 1ns/1ps
module serdes_transmit_encoder (
  input  wire logic                                clk_sys,
  input  wire logic                                rstn,
  input  wire logic [serdes_tx_pkg::WORD_BITS-1:0] parallel_transmit_bus,
  input  wire logic                                low_byte_control_select,
  input  wire logic                                high_byte_control_select,
  input  wire logic                                test_pattern_enable,
  output logic                                     word_take,
  output logic                                     reference_word_clock,
  output logic                                     serial_out
);
  import serdes_tx_pkg::*;

  localparam int lat_m1 = TX_LATENCY_BITS - 1;

  logic [4:0]            cnt_r;
  logic [4:0]            cnt_nxt;
  logic                  word_slot;
  logic                  enc_slot;
  logic [WORD_BITS-1:0]  cap_data_r;
  logic                  cap_klo_r;
  logic                  cap_khi_r;
  tx_mode_t              mode_r;
  logic                  rd_r;
  logic [SER_BITS-1:0]   enc_r;
  logic [SER_BITS-1:0]   shift_r;
  logic [SER_BITS-1:0]   prbs_chunk;
  logic [DELAY_BITS-1:0] dly_r;
  logic                  ref_clk_r;

  enc_if lo_if ();
  enc_if hi_if ();

  function automatic int ones_of(input logic [SER_BITS-1:0] v);
    int n;
    n = 0;
    for (int i = 0; i < SER_BITS; i++) begin
      n += int'(v[i]);
    end
    return n;
  endfunction

  // true when every bit from the eighth on follows x^7 + x^6 + 1
  function automatic logic prbs_ok(input logic [SER_BITS-1:0] v);
    logic ok;
    ok = 1'h1;
    for (int i = 7; i < SER_BITS; i++) begin
      ok &= v[i] == (v[i-7] ^ v[i-6]);
    end
    return ok;
  endfunction

  // word slot timing: one serial bit per clock, 20 per word
  always_comb begin
    cnt_nxt = (cnt_r == SLOT_LAST) ? SLOT_RESET : cnt_r + 5'h01;
  end

  assign word_slot = cnt_r == SLOT_LAST;
  assign enc_slot  = cnt_r == SLOT_ENC;
  assign word_take = word_slot;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= SLOT_LAST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // word clock seen by the partner, high for the first half slot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_clk_r <= 1'h0;
    end else begin
      ref_clk_r <= cnt_nxt < SLOT_HALF;
    end
  end

  assign reference_word_clock = ref_clk_r;

  // capture of the parallel word and both control selects
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cap_data_r <= '0;
      cap_klo_r  <= 1'h0;
      cap_khi_r  <= 1'h0;
    end else if (word_slot) begin
      cap_data_r <= parallel_transmit_bus;
      cap_klo_r  <= low_byte_control_select;
      cap_khi_r  <= high_byte_control_select;
    end
  end

  // mode changes only on word boundaries
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_r <= MODE_DATA;
    end else if (word_slot) begin
      mode_r <= test_pattern_enable ? MODE_PRBS : MODE_DATA;
    end
  end

  // two byte encoders, high one fed the low one's disparity, chained low to high
  assign lo_if.byte_in = cap_data_r[7:0];
  assign lo_if.is_k    = cap_klo_r;
  assign lo_if.rd_in   = rd_r;
  assign hi_if.byte_in = cap_data_r[15:8];
  assign hi_if.is_k    = cap_khi_r;
  assign hi_if.rd_in   = lo_if.rd_out;

  enc_8b10b u_enc_lo (
    .e (lo_if.enc)
  );

  enc_8b10b u_enc_hi (
    .e (hi_if.enc)
  );

  prbs7_gen #(
    .WIDTH (SER_BITS)
  ) u_prbs (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .step    (enc_slot),
    .chunk_r (prbs_chunk)
  );

  // running disparity, held while the test pattern runs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_r <= RD_RESET;
    end else if (enc_slot && mode_r == MODE_DATA) begin
      rd_r <= hi_if.rd_out;
    end
  end

  // serialiser input register: encoded pair or test pattern
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enc_r <= '0;
    end else if (enc_slot) begin
      if (mode_r == MODE_PRBS) begin
        enc_r <= prbs_chunk;
      end else begin
        enc_r <= {hi_if.sym, lo_if.sym};
      end
    end
  end

  // shifter, low symbol bit 0 first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_r <= '0;
    end else if (word_slot) begin
      shift_r <= enc_r;
    end else begin
      shift_r <= shift_r >> 1;
    end
  end

  // fixed delay line that sets the transmit latency
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[DELAY_BITS-2:0], shift_r[0]};
    end
  end

  assign serial_out = dly_r[DELAY_BITS-1];

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (!rstn);

  chk_slot_wrap: assert property (
    word_slot |=> (cnt_r == 5'h00) ##19 word_slot
  ) else $error("word slot is not 20 clocks long");

  chk_word_clock: assert property (
    word_slot |=> reference_word_clock [*8] ##3 !reference_word_clock [*8]
  ) else $error("word clock shape wrong");

  chk_capture_word: assert property (
    word_slot |=> cap_data_r == $past(parallel_transmit_bus)
      && cap_klo_r == $past(low_byte_control_select)
      && cap_khi_r == $past(high_byte_control_select)
  ) else $error("parallel word not captured");

  chk_low_kind: assert property (
    (enc_slot && mode_r == MODE_DATA && cap_data_r[4:0] == K28_X)
      |=> ((&enc_r[5:2]) || !(|enc_r[5:2])) == $past(cap_klo_r)
  ) else $error("low byte K or D choice wrong");

  chk_high_kind: assert property (
    (enc_slot && mode_r == MODE_DATA && cap_data_r[12:8] == K28_X)
      |=> ((&enc_r[15:12]) || !(|enc_r[15:12])) == $past(cap_khi_r)
  ) else $error("high byte K or D choice wrong");

  chk_word_balance: assert property (
    (enc_slot && mode_r == MODE_DATA)
      |=> ones_of(enc_r) >= 8 && ones_of(enc_r) <= 12
  ) else $error("encoded word out of balance");

  chk_disp_low: assert property (
    (enc_slot && mode_r == MODE_DATA && !rd_r)
      |=> ones_of({10'h000, enc_r[9:0]}) >= 5
  ) else $error("low symbol ignores negative disparity");

  chk_shift_load: assert property (
    word_slot |=> shift_r == $past(enc_r)
  ) else $error("shifter not loaded with encoded word");

  chk_lsb_first: assert property (
    word_slot |=> ##1 shift_r[0] == $past(enc_r[1], 2)
  ) else $error("serial order is not lsb first");

  chk_fixed_latency: assert property (
    (cnt_r == 5'h01) |-> ##lat_m1 serial_out == $past(enc_r[0], lat_m1)
  ) else $error("first serial bit not 36 bit times after capture");

  chk_prbs_inject: assert property (
    (enc_slot && mode_r == MODE_PRBS) |=> enc_r == $past(prbs_chunk)
  ) else $error("test pattern not injected");

  chk_prbs_rd_hold: assert property (
    (enc_slot && mode_r == MODE_PRBS) |=> rd_r == $past(rd_r)
  ) else $error("disparity moved in test mode");

  chk_prbs_live: assert property (
    (enc_slot && mode_r == MODE_PRBS) |=> enc_r != '0
  ) else $error("test sequence stuck at zero");

  chk_take_pulse: assert property (
    word_take |=> !word_take
  ) else $error("word take longer than one clock");

  chk_take_clock: assert property (
    word_take |-> !reference_word_clock
  ) else $error("word clock high at capture");

  chk_ref_rise: assert property (
    $rose(reference_word_clock) |-> $past(word_slot)
  ) else $error("word clock rose off the word boundary");

  chk_capture_hold: assert property (
    !word_slot |=> $stable(cap_data_r) && $stable(cap_klo_r)
      && $stable(cap_khi_r)
  ) else $error("captured word changed inside a slot");

  chk_mode_follow: assert property (
    word_slot |=> (mode_r == MODE_PRBS) == $past(test_pattern_enable)
  ) else $error("test mode does not follow its enable");

  chk_mode_hold: assert property (
    !word_slot |=> $stable(mode_r)
  ) else $error("mode changed inside a word slot");

  chk_enc_hold: assert property (
    !enc_slot |=> $stable(enc_r)
  ) else $error("serialiser input changed inside a slot");

  chk_shift_step: assert property (
    !word_slot |=> shift_r == ($past(shift_r) >> 1)
  ) else $error("shifter did not move one bit");

  chk_rd_carry: assert property (
    (enc_slot && mode_r == MODE_DATA) |=> rd_r == ($past(rd_r)
      ^ (ones_of({10'h000, enc_r[9:0]}) != 5)
      ^ (ones_of({10'h000, enc_r[19:10]}) != 5))
  ) else $error("disparity not carried to next word");

  chk_disp_high: assert property (
    (enc_slot && mode_r == MODE_DATA)
      |=> (($past(rd_r) ^ (ones_of({10'h000, enc_r[9:0]}) != 5))
        ? ones_of({10'h000, enc_r[19:10]}) <= 5
        : ones_of({10'h000, enc_r[19:10]}) >= 5)
  ) else $error("high symbol ignores disparity from low symbol");

  chk_prbs_chain: assert property (
    (enc_slot && mode_r == MODE_PRBS) |=> prbs_ok(enc_r)
  ) else $error("test sequence breaks its recurrence");
endmodule // serdes_transmit_encoder

//--- rtl/serdes_tx_pkg.sv
package serdes_tx_pkg;
  localparam int         WORD_BITS       = 16;
  localparam int         SYM_BITS        = 10;
  localparam int         SER_BITS        = 20;
  localparam logic [4:0] SLOT_LAST       = 5'(SER_BITS - 1);
  localparam logic [4:0] SLOT_ENC        = 5'h00;
  localparam logic [4:0] SLOT_HALF       = 5'h0A;
  localparam logic [4:0] SLOT_RESET      = 5'h00;
  localparam int         TX_LATENCY_BITS = 36;
  localparam int         PIPE_BITS       = 20;
  localparam int         DELAY_BITS      = TX_LATENCY_BITS - PIPE_BITS;
  localparam logic       RD_RESET        = 1'h0;
  localparam logic [6:0] PRBS_SEED       = 7'h7F;
  localparam logic [4:0] K28_X           = 5'h1C;
  localparam logic [5:0] K28_CODE6       = 6'h0F;

  typedef enum logic {
    MODE_DATA = 1'h0,
    MODE_PRBS = 1'h1
  } tx_mode_t;
endpackage
